/* File: rtl/fsap_top.sv */
// Status registers and array protection decode of a serial NOR flash.
// Behaviour
// - Invert set: code 000 all, 111 none.
// - Invert, selects 00: shield low fractions.
// - Invert, selects 01: shield upper fractions.
// - Invert, selects 10: all but top sector.
// - Invert, selects 11: all but bottom sector.
// - Byte zero: lock0, protect selects, retained.
// - Write latch bit1, busy bit0, volatile.
// - Erase paused bit15, program paused bit10.
// - Invert bit14, OTP security locks 13..11.
// - Four-line enable bit9, lock1 bit8.
// - Pin select bit23, drive strength 22..21.
// - Wait config 17..16, bits 20..18 reserved.
// - Invert clear: plain top/bottom regions.
// - Reject program/erase inside shielded region.
// - Chip erase only with open selects.
// - Busy while program, erase, status write.
module fsap_top
    import fsap_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire fsap_pkg::fsap_cmd_t cmd_code,
    input wire logic [1:0] cmd_sel,
    input wire logic [7:0] cmd_data,
    input wire logic [fsap_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic op_done,
    input wire logic [1:0] rd_sel,
    output logic [7:0] rd_data,
    output logic op_start,
    output logic op_reject,
    output fsap_pkg::fsap_op_t op_kind,
    output logic [fsap_pkg::ADDR_W-1:0] op_addr,
    output logic busy_flag,
    output logic four_line_enable,
    output logic pin_sel_reset,
    output logic [1:0] drive_level,
    output logic [1:0] wait_cfg,
    output logic [2:0] secreg_lock
);
    import fsap_pkg::*;

    fsap_state_t state_ff;
    fsap_state_t nxt_state;
    fsap_op_t op_kind_ff;
    logic [23:0] nv_ff;
    logic [23:0] nxt_nv;
    logic [23:0] lane_mask;
    logic [23:0] status_word;
    logic write_latch_ff;
    logic erase_paused_ff;
    logic program_paused_ff;
    logic op_start_ff;
    logic op_reject_ff;
    logic [ADDR_W-1:0] op_addr_ff;
    logic [7:0] rd_data_ff;
    logic [4:0] sel;
    logic inv;
    logic prot_hit;
    logic chip_ok;
    logic is_prog;
    logic is_wipe;
    logic take;

    assign sel = nv_ff[B_SEL0 +: 5];
    assign inv = nv_ff[B_INVERT];

    function automatic logic shield(input logic [4:0] s, input logic cmp,
                                    input logic [ADDR_W-1:0] a);
        logic [4:0] e;
        logic [ADDR_W-1:0] m;
        logic hit;
        e = 5'h00;
        m = '0;
        hit = 1'b0;
        if (s[4])
        begin
            e = (s[2:0] < SEL_SMALL_CAP) ? EXP_BASE_SMALL + {2'h0, s[2:0]} : EXP_SMALL_MAX;
        end
        else
        begin
            e = EXP_BASE_LARGE + {2'h0, s[2:0]};
        end
        m = {ADDR_W{1'b1}} << e;
        if (s[2:0] == SEL_NONE)
        begin
            hit = 1'b0;
        end
        else if (s[2:0] == SEL_ALL)
        begin
            hit = 1'b1;
        end
        else if (s[3])
        begin
            hit = ((a & m) == '0);
        end
        else
        begin
            hit = ((a & m) == m);
        end
        return cmp ? ~hit : hit;
    endfunction

    assign prot_hit = shield(sel, inv, cmd_addr);
    assign chip_ok = ((sel[2:0] == SEL_NONE) && !inv) || ((sel[2:0] == SEL_ALL) && inv);
    assign is_prog = (cmd_code == CMD_PAGE_WRITE);
    assign is_wipe = (cmd_code == CMD_WIPE_SMALL) || (cmd_code == CMD_BLOCK_WIPE);
    assign take = cmd_valid && (state_ff == ST_IDLE) && write_latch_ff;

    always_comb
    begin
        unique case (cmd_sel)
            2'h0: lane_mask = WR_MASK & 24'h0000ff;
            2'h1: lane_mask = WR_MASK & 24'h00ff00;
            2'h2: lane_mask = WR_MASK & 24'hff0000;
            default: lane_mask = 24'h000000;
        endcase
    end

    // status writes never return security locks to zero; reset clears them
    assign nxt_nv = (nv_ff & ~lane_mask) | ({3{cmd_data}} & lane_mask) | (nv_ff & OTP_MASK);

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            nv_ff <= NV_RESET;
        end
        else if (take && cmd_code == CMD_STATUS_WR)
        begin
            nv_ff <= nxt_nv;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            write_latch_ff <= 1'b0;
        end
        else if (cmd_valid && state_ff == ST_IDLE)
        begin
            unique case (cmd_code)
                CMD_LATCH_SET: write_latch_ff <= 1'b1;
                CMD_LATCH_CLR, CMD_STATUS_WR, CMD_PAGE_WRITE,
                CMD_WIPE_SMALL, CMD_BLOCK_WIPE, CMD_CHIP_WIPE,
                CMD_SOFT_RESET: write_latch_ff <= 1'b0;
                default: write_latch_ff <= write_latch_ff;
            endcase
        end
        else if (cmd_valid && cmd_code == CMD_SOFT_RESET)
        begin
            write_latch_ff <= 1'b0;
        end
    end

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:
            begin
                if (take && (cmd_code == CMD_STATUS_WR))
                begin
                    nxt_state = ST_RUN;
                end
                else if (take && (is_prog || is_wipe) && !prot_hit)
                begin
                    nxt_state = ST_RUN;
                end
                else if (take && (cmd_code == CMD_CHIP_WIPE) && chip_ok)
                begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (op_done)
                begin
                    nxt_state = ST_IDLE;
                end
                else if (cmd_valid && cmd_code == CMD_PAUSE && op_kind_ff != OP_STATUS)
                begin
                    nxt_state = ST_PAUSE;
                end
            end
            ST_PAUSE:
            begin
                if (cmd_valid && cmd_code == CMD_RESUME)
                begin
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (cmd_valid && cmd_code == CMD_SOFT_RESET)
        begin
            nxt_state = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= ST_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // start or refuse program and erase
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            op_start_ff <= 1'b0;
            op_reject_ff <= 1'b0;
            op_kind_ff <= OP_STATUS;
            op_addr_ff <= '0;
        end
        else
        begin
            op_start_ff <= (state_ff == ST_IDLE) && (nxt_state == ST_RUN);
            op_reject_ff <= take && (((is_prog || is_wipe) && prot_hit)
                || ((cmd_code == CMD_CHIP_WIPE) && !chip_ok));
            if (state_ff == ST_IDLE && nxt_state == ST_RUN)
            begin
                op_addr_ff <= cmd_addr;
                if (cmd_code == CMD_STATUS_WR)
                begin
                    op_kind_ff <= OP_STATUS;
                end
                else if (is_prog)
                begin
                    op_kind_ff <= OP_PROG;
                end
                else if (is_wipe)
                begin
                    op_kind_ff <= OP_ERASE;
                end
                else
                begin
                    op_kind_ff <= OP_CHIP;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            erase_paused_ff <= 1'b0;
            program_paused_ff <= 1'b0;
        end
        else if (state_ff == ST_RUN && nxt_state == ST_PAUSE)
        begin
            erase_paused_ff <= (op_kind_ff != OP_PROG);
            program_paused_ff <= (op_kind_ff == OP_PROG);
        end
        else if (state_ff == ST_PAUSE && nxt_state != ST_PAUSE)
        begin
            erase_paused_ff <= 1'b0;
            program_paused_ff <= 1'b0;
        end
    end

    // volatile bits placed over stored word
    always_comb
    begin
        status_word = nv_ff & ~RSVD_MASK;
        status_word[B_BUSY] = (state_ff == ST_RUN);
        status_word[B_LATCH] = write_latch_ff;
        status_word[B_PROG_PAUSED] = program_paused_ff;
        status_word[B_ERASE_PAUSED] = erase_paused_ff;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_data_ff <= 8'h00;
        end
        else
        begin
            unique case (rd_sel)
                2'h0: rd_data_ff <= status_word[7:0];
                2'h1: rd_data_ff <= status_word[15:8];
                2'h2: rd_data_ff <= status_word[23:16];
                default: rd_data_ff <= 8'h00;
            endcase
        end
    end

    assign rd_data = rd_data_ff;
    assign op_start = op_start_ff;
    assign op_reject = op_reject_ff;
    assign op_kind = op_kind_ff;
    assign op_addr = op_addr_ff;
    assign busy_flag = (state_ff == ST_RUN);
    assign four_line_enable = nv_ff[B_QUAD];
    assign pin_sel_reset = nv_ff[B_PIN_SEL];
    assign drive_level = nv_ff[B_DRIVE +: 2];
    assign wait_cfg = nv_ff[B_WAIT_CFG +: 2];
    assign secreg_lock = nv_ff[B_SECLOCK +: 3];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    a_inv_full_shield: assert property (inv && sel[2:0] == SEL_NONE |-> prot_hit)
        else $error("invert with code 000 left an address open");
    a_inv_upper_half: assert property (inv && sel == 5'h0e |-> prot_hit == cmd_addr[23])
        else $error("upper half shield wrong");
    a_plain_top_slice: assert property (!inv && sel == 5'h01 |->
        prot_hit == (cmd_addr[23:18] == 6'h3f))
        else $error("top 256KB shield wrong");
    a_inv_top_open: assert property (inv && sel == 5'h11 |->
        prot_hit == (cmd_addr[23:12] != 12'hfff))
        else $error("top 4KB opening wrong");
    a_shield_refuse: assert property (take && is_prog && prot_hit |=>
        op_reject_ff && !op_start_ff ##1 state_ff == ST_IDLE)
        else $error("shielded program was not refused");
    a_chip_gate: assert property (op_start_ff && op_kind_ff == OP_CHIP |->
        $past(chip_ok))
        else $error("chip erase started while shielded");
    a_latch_needed: assert property (op_start_ff |-> $past(write_latch_ff) && !write_latch_ff)
        else $error("operation without write latch");
    a_busy_done: assert property (busy_flag && op_done && !$past(op_done) |=> !busy_flag)
        else $error("busy stayed after completion");
    a_otp_sticky: assert property (((($past(nv_ff) & OTP_MASK) & ~nv_ff) == 24'h000000))
        else $error("security lock returned to zero");
    a_rsvd_zero: assert property ($past(rd_sel) == 2'h2 |-> rd_data_ff[4:2] == 3'h0)
        else $error("reserved bit read nonzero");
    a_pause_flag: assert property (state_ff == ST_RUN && nxt_state == ST_PAUSE |=>
        (erase_paused_ff ^ program_paused_ff) && !busy_flag)
        else $error("suspend flags wrong");

    c_refuse: cover property (take && is_wipe && prot_hit ##1 op_reject_ff);
    c_chip: cover property (op_start_ff && op_kind_ff == OP_CHIP);
    c_pause: cover property (state_ff == ST_PAUSE ##1 state_ff == ST_RUN);

endmodule

/* File: rtl/fsap_pkg.sv */
// Constants and types of the flash status and array protection block.
package fsap_pkg;

    localparam int ADDR_W = 24;

    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_LATCH_SET = 4'h1,
        CMD_LATCH_CLR = 4'h2,
        CMD_STATUS_WR = 4'h3,
        CMD_PAGE_WRITE = 4'h4,
        CMD_WIPE_SMALL = 4'h5,
        CMD_BLOCK_WIPE = 4'h6,
        CMD_CHIP_WIPE = 4'h7,
        CMD_PAUSE = 4'h8,
        CMD_RESUME = 4'h9,
        CMD_SOFT_RESET = 4'ha
    } fsap_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_PAUSE = 2'b10
    } fsap_state_t;

    typedef enum logic [1:0] {
        OP_STATUS = 2'b00,
        OP_PROG = 2'b01,
        OP_ERASE = 2'b10,
        OP_CHIP = 2'b11
    } fsap_op_t;

    // Bit positions in the 24-bit status word.
    localparam int B_BUSY = 0;
    localparam int B_LATCH = 1;
    localparam int B_SEL0 = 2;
    localparam int B_LOCK0 = 7;
    localparam int B_LOCK1 = 8;
    localparam int B_QUAD = 9;
    localparam int B_PROG_PAUSED = 10;
    localparam int B_SECLOCK = 11;
    localparam int B_INVERT = 14;
    localparam int B_ERASE_PAUSED = 15;
    localparam int B_WAIT_CFG = 16;
    localparam int B_DRIVE = 21;
    localparam int B_PIN_SEL = 23;

    localparam logic [23:0] WR_MASK = 24'he37bfc;
    localparam logic [23:0] OTP_MASK = 24'h003800;
    localparam logic [23:0] RSVD_MASK = 24'h1c0000;
    localparam logic [23:0] NV_RESET = 24'h000000;

    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_ALL = 3'h7;
    localparam logic [2:0] SEL_SMALL_CAP = 3'h4;
    localparam logic [4:0] EXP_BASE_LARGE = 5'h11;
    localparam logic [4:0] EXP_BASE_SMALL = 5'h0b;
    localparam logic [4:0] EXP_SMALL_MAX = 5'h0f;

endpackage

/* File: verification/fsap_engine_model.sv */
// Array engine stand-in that ends each started operation after a set delay.
module fsap_engine_model
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic op_start,
    input wire logic busy_flag,
    input wire logic [7:0] delay_cyc,
    output logic op_done
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] cnt_ff;
    logic armed_ff;

    // The count freezes while the block is paused, as a suspended engine would.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_ff <= 8'h00;
            armed_ff <= 1'b0;
            op_done <= 1'b0;
        end
        else
        begin
            op_done <= 1'b0;
            if (op_start)
            begin
                cnt_ff <= delay_cyc;
                armed_ff <= 1'b1;
            end
            else if (armed_ff && busy_flag)
            begin
                if (cnt_ff == 8'h00)
                begin
                    op_done <= 1'b1;
                    armed_ff <= 1'b0;
                end
                else
                    cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the flash status and array protection block.
module tb_top
    import fsap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam fsap_cmd_t PW = CMD_PAGE_WRITE;
    localparam fsap_cmd_t SW = CMD_WIPE_SMALL;
    localparam fsap_cmd_t BW = CMD_BLOCK_WIPE;
    localparam fsap_cmd_t CW = CMD_CHIP_WIPE;

    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    fsap_cmd_t cmd_code = CMD_NONE;
    logic [1:0] cmd_sel = 2'h0;
    logic [7:0] cmd_data = 8'h00;
    logic [23:0] cmd_addr = 24'h000000;
    logic [1:0] rd_sel = 2'h0;
    logic [7:0] delay_cyc = 8'h02;
    logic op_done, op_start, op_reject, busy_flag, four_line_enable, pin_sel_reset;
    logic [7:0] rd_data;
    fsap_op_t op_kind;
    logic [23:0] op_addr;
    logic [1:0] drive_level, wait_cfg;
    logic [2:0] secreg_lock;
    int n_errors = 0;
    int num_checks = 0;

    always #2 clk_sys = ~clk_sys;

    fsap_top i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_sel(cmd_sel), .cmd_data(cmd_data), .cmd_addr(cmd_addr),
        .op_done(op_done), .rd_sel(rd_sel), .rd_data(rd_data), .op_start(op_start),
        .op_reject(op_reject), .op_kind(op_kind), .op_addr(op_addr), .busy_flag(busy_flag),
        .four_line_enable(four_line_enable), .pin_sel_reset(pin_sel_reset),
        .drive_level(drive_level), .wait_cfg(wait_cfg), .secreg_lock(secreg_lock));

    fsap_engine_model i_engine (.clk_sys(clk_sys), .rst_b(rst_b), .op_start(op_start),
        .busy_flag(busy_flag), .delay_cyc(delay_cyc), .op_done(op_done));

    task automatic give_verdict();
        if (n_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic cmd(input fsap_cmd_t code, input logic [1:0] sel, input logic [7:0] data,
        input logic [23:0] addr);
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_sel = sel;
        cmd_data = data;
        cmd_addr = addr;
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'b0;
    endtask

    task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
        @(posedge clk_sys);
        #1;
        rd_sel = sel;
        @(posedge clk_sys);
        #1;
        chk({16'h0000, rd_data}, {16'h0000, exp}, "status byte");
    endtask

    // A hang here ends the run rather than stalling it.
    task automatic wait_idle();
        for (int i = 0; i < 300 && busy_flag !== 1'b0; i++)
        begin
            @(posedge clk_sys);
            #1;
        end
        if (busy_flag !== 1'b0)
        begin
            n_errors++;
            $display("[ERR] %0t busy stuck", $time);
            give_verdict();
        end
    endtask

    task automatic sw(input logic [1:0] sel, input logic [7:0] data);
        cmd(CMD_LATCH_SET, 2'h0, 8'h00, 24'h000000);
        cmd(CMD_STATUS_WR, sel, data, 24'h000000);
        wait_idle();
    endtask

    task automatic prot(input logic [4:0] sel, input logic inv, input fsap_cmd_t code,
        input logic [23:0] addr, input logic ok);
        sw(2'h0, {1'b0, sel, 2'b00});
        sw(2'h1, {1'b0, inv, 6'h38});
        cmd(CMD_LATCH_SET, 2'h0, 8'h00, 24'h000000);
        cmd(code, 2'h0, 8'h00, addr);
        chk({23'h0, op_start}, {23'h0, ok}, "start");
        chk({23'h0, busy_flag}, {23'h0, ok}, "busy");
        if (code != CW)
            chk({23'h0, op_reject}, {23'h0, !ok}, "reject");
        if (ok)
        begin
            chk({22'h0, op_kind}, {22'h0, (code == PW) ? OP_PROG :
                (code == CW) ? OP_CHIP : OP_ERASE}, "kind");
            if (code != CW)
                chk(op_addr, addr, "addr");
            wait_idle();
        end
    endtask

    initial
    begin
        repeat (12) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h3, 8'h00);
        cmd(CMD_STATUS_WR, 2'h2, 8'hff, 24'h000000);
        rd(2'h2, 8'h00);
        cmd(CMD_LATCH_SET, 2'h0, 8'h00, 24'h000000);
        rd(2'h0, 8'h02);
        cmd(CMD_LATCH_CLR, 2'h0, 8'h00, 24'h000000);
        rd(2'h0, 8'h00);
        cmd(CMD_LATCH_SET, 2'h0, 8'h00, 24'h000000);
        cmd(CMD_STATUS_WR, 2'h2, 8'hff, 24'h000000);
        chk({23'h0, busy_flag}, 24'h000001, "wr busy");
        wait_idle();
        rd(2'h2, 8'he3);
        chk({19'h0, pin_sel_reset, drive_level, wait_cfg}, 24'h00001f, "cfg");
        sw(2'h1, 8'hff);
        rd(2'h1, 8'h7b);
        chk({20'h0, four_line_enable, secreg_lock}, 24'h00000f, "mid");
        sw(2'h1, 8'h84);
        rd(2'h1, 8'h38);
        sw(2'h0, 8'hff);
        rd(2'h0, 8'hfc);
        prot(5'h00, 1'b1, PW, 24'hffffff, 1'b0);
        prot(5'h07, 1'b1, SW, 24'h000000, 1'b1);
        prot(5'h01, 1'b1, BW, 24'hfbffff, 1'b0);
        prot(5'h01, 1'b1, PW, 24'hfc0000, 1'b1);
        prot(5'h06, 1'b1, PW, 24'h7fffff, 1'b0);
        prot(5'h06, 1'b1, SW, 24'h800000, 1'b1);
        prot(5'h09, 1'b1, PW, 24'h040000, 1'b0);
        prot(5'h09, 1'b1, SW, 24'h03ffff, 1'b1);
        prot(5'h0e, 1'b1, BW, 24'h800000, 1'b0);
        prot(5'h11, 1'b1, PW, 24'hffefff, 1'b0);
        prot(5'h11, 1'b1, PW, 24'hfff000, 1'b1);
        prot(5'h15, 1'b1, SW, 24'hff8000, 1'b1);
        prot(5'h19, 1'b1, PW, 24'h001000, 1'b0);
        prot(5'h19, 1'b1, PW, 24'h000fff, 1'b1);
        prot(5'h1d, 1'b1, BW, 24'h008000, 1'b0);
        prot(5'h01, 1'b0, PW, 24'hfc0000, 1'b0);
        prot(5'h01, 1'b0, SW, 24'hfbffff, 1'b1);
        prot(5'h00, 1'b0, CW, 24'h000000, 1'b1);
        prot(5'h01, 1'b0, CW, 24'h000000, 1'b0);
        prot(5'h07, 1'b1, CW, 24'h000000, 1'b1);
        prot(5'h00, 1'b1, CW, 24'h000000, 1'b0);
        delay_cyc = 8'h14;
        sw(2'h1, 8'h38);
        cmd(CMD_LATCH_SET, 2'h0, 8'h00, 24'h000000);
        cmd(BW, 2'h0, 8'h00, 24'h100000);
        cmd(CMD_PAUSE, 2'h0, 8'h00, 24'h000000);
        chk({23'h0, busy_flag}, 24'h000000, "paused busy");
        rd(2'h1, 8'hb8);
        cmd(CMD_RESUME, 2'h0, 8'h00, 24'h000000);
        chk({23'h0, busy_flag}, 24'h000001, "resumed busy");
        rd(2'h1, 8'h38);
        wait_idle();
        cmd(CMD_LATCH_SET, 2'h0, 8'h00, 24'h000000);
        cmd(PW, 2'h0, 8'h00, 24'h000100);
        cmd(CMD_PAUSE, 2'h0, 8'h00, 24'h000000);
        rd(2'h1, 8'h3c);
        cmd(CMD_SOFT_RESET, 2'h0, 8'h00, 24'h000000);
        rd(2'h1, 8'h38);
        rd(2'h2, 8'he3);
        rst_b = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        rd(2'h2, 8'h00);
        give_verdict();
    end
endmodule
